// File: testbench/gcg_testbench.sv
// Self-checking bench for the clock generator control block.
`timescale 1ns/1ps
`include "gcg_defines.svh"

module testbench;
  // ==========================================================================
  // Signals and tables
  localparam int G = 9;
  localparam logic [11:0] CTL = `GCG_CTRL_OFF;
  localparam logic [11:0] STA = `GCG_STAT_OFF;
  localparam logic [32:0] ALL = 33'h1_ffff_ffff;
  localparam logic [31:0] DW[5] = '{32'h0009_0604, 32'h000b_0604,
    32'h0019_0604, 32'h0009_0604, 32'h001b_0604};
  localparam int DF[5] = '{1, 3, 1, 4, 0};
  localparam int DE[5] = '{48, 16, 12, 12, 24};
  localparam logic [31:0] PW[5] = '{32'h000c_0604, 32'h0009_0604,
    32'h002d_0604, 32'h0005_0604, 32'h0009_0104};
  localparam logic PS[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  localparam int PE[5] = '{0, 0, 48, 0, -1};
  localparam logic PL[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  localparam logic PO[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic               core_clk = 1'b0;
  logic               resetn, user_reset, standby, psel, penable, pwrite;
  logic               pready, pslverr;
  logic [G-1:0]       periph_req, write_lock, rtc_source, pin_i;
  logic [G-1:0]       pin_o, pin_oe, gen_clk;
  logic [G-1:0][15:0] div_f;
  logic [6:0]         osc;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic [3:0]         pstrb, tick;
  logic [31:0]        word_q[G];
  logic [32:0]        exp_q[$];
  logic [32:0]        msk_q[$];
  int                 fail_count = 0;
  int                 checked = 0;

  // Free-running core clock and slow source toggles every ten cycles.
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    tick <= (tick == 4'h9) ? 4'h0 : tick + 4'h1;
    if (tick == 4'h9) begin
      osc   <= ~osc;
      pin_i <= ~pin_i;
    end
  end

  gcg_top #(.NUM_GEN(G), .DIV_W(16)) i_dut (
    .core_clk_i(core_clk), .resetn_i(resetn), .user_reset_i(user_reset),
    .standby_i(standby), .periph_req_i(periph_req),
    .write_lock_i(write_lock), .rtc_source_i(rtc_source),
    .division_factor_i(div_f), .osc_clk_i(osc), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe), .gen_clk_o(gen_clk));

  // ==========================================================================
  // Tasks
  task automatic check(input logic [32:0] seen, input logic [32:0] exp,
                       input string msg);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen,
               exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // One APB transfer, entered just after a rising edge, idle edge after it.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e,
                    input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask : rd

  // Byte write of the selector, then a read of the chosen generator.
  task automatic rd_gen(input int g, input logic [31:0] e);
    apb(1'b1, CTL, 32'(g), 4'h1);
    rd(CTL, {1'b0, e}, ALL);
  endtask : rd_gen

  task automatic measure(input int g, output int ge, output int pe,
                         output int hi);
    logic pg, pp;
    ge = 0;
    pe = 0;
    hi = 0;
    repeat (30) @(posedge core_clk);
    pg = gen_clk[g];
    pp = pin_o[g];
    repeat (960) begin
      @(posedge core_clk);
      ge += int'(gen_clk[g] && !pg);
      pe += int'(pin_o[g] && !pp);
      hi += int'(gen_clk[g]);
      pg = gen_clk[g];
      pp = pin_o[g];
    end
  endtask : measure

  function automatic logic [31:0] rst_word(input int g);
    if (g == 0) return `GCG_GEN0_RST;
    if (g == 2) return `GCG_GEN2_RST;
    return 32'(g);
  endfunction : rst_word

  function automatic logic [32:0] near(input int s, input int e, input int t);
    return (s >= e - t && s <= e + t) ? 33'(e) : 33'(s);
  endfunction : near

  // Read results are compared against the oldest expectation in the queue.
  always @(posedge core_clk) begin
    if (psel && penable && !pwrite && pready && exp_q.size() > 0) begin
      check({pslverr, prdata} & msk_q[0], exp_q[0] & msk_q[0], "read");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  // Watchdog ends a hung run.
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    int ge, pe, hi;
    logic [31:0] w;
    {resetn, user_reset, standby, psel, penable, pwrite} = '0;
    {paddr, pwdata, pstrb, tick, osc, pin_i} = '0;
    void'($urandom(86670));
    periph_req = G'($urandom) & 9'h1ef;
    {write_lock, rtc_source} = '0;
    for (int g = 0; g < G; g++) div_f[g] = 16'($urandom);
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    apb(1'b1, CTL, 32'h0039_1f09, 4'hf);
    for (int g = 0; g < G; g++) rd_gen(g, rst_word(g));
    rd(12'h020, 33'h1_0000_0000, ALL);
    $display("test reset values done");

    write_lock <= G'($urandom);
    rtc_source <= G'($urandom);
    for (int g = 0; g < G; g++) begin
      w = $urandom;
      w[12:8] = 5'($urandom_range(8));
      w[3:0] = 4'(g);
      apb(1'b1, CTL, w, 4'hf);
      word_q[g] = w & ~`GCG_RSV_MASK;
      rd_gen(g, word_q[g]);
    end
    user_reset <= 1'b1;
    @(posedge core_clk);
    user_reset <= 1'b0;
    @(posedge core_clk);
    for (int g = 0; g < G; g++) begin
      w = (g > 0 && (write_lock[g] || rtc_source[g])) ? word_q[g]
          : rst_word(g);
      rd_gen(g, w);
    end
    $display("test user reset done");

    standby <= 1'b1;
    apb(1'b1, CTL, 32'h0021_0604, 4'hf);
    rd(STA, 33'h0, 33'h10);
    periph_req[4] <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(STA, 33'h10, 33'h10);
    standby <= 1'b0;
    periph_req[4] <= 1'b0;
    $display("test peripheral request done");

    for (int r = 0; r < 5; r++) begin
      div_f[4] <= 16'(DF[r]);
      apb(1'b1, CTL, DW[r], 4'hf);
      measure(4, ge, pe, hi);
      check(near(ge, DE[r], 1), 33'(DE[r]), "clock edges");
      check(33'(pe), 33'(ge), "pin edges");
      check(near(hi, 480, 40), 33'd480, "high time");
    end
    $display("test dividers done");

    div_f[4] <= 16'h1;
    for (int r = 0; r < 5; r++) begin
      standby <= PS[r];
      apb(1'b1, CTL, PW[r], 4'hf);
      measure(4, ge, pe, hi);
      check({32'h0, pin_oe[4]}, {32'h0, PO[r]}, "pin enable");
      if (PE[r] > 0) check(near(pe, PE[r], 1), 33'(PE[r]), "standby run");
      if (PE[r] == 0) check({pe, pin_o[4]}, {32'h0, PL[r]}, "off level");
    end
    standby <= 1'b0;
    $display("test pin levels done");
    end_of_test();
  end

endmodule : testbench

// File: verilog/gcg_defines.svh
// Register offsets, field positions and reset values of the generators.
`ifndef GCG_DEFINES_SVH
`define GCG_DEFINES_SVH

// ==========================================================================
// Register map
`define GCG_CTRL_OFF     12'h004
`define GCG_STAT_OFF     12'h010
`define GCG_ADDR_W       12

// ==========================================================================
// Field positions of the control and status words
`define GCG_ID_LSB       0
`define GCG_ID_W         4
`define GCG_SRC_LSB      8
`define GCG_SRC_W        5
`define GCG_FLAG_LSB     16
`define GCG_FLAG_W       6
`define GCG_RSV_MASK     32'hffc0e0f0
`define GCG_STAT_RUN_LSB 0
`define GCG_STAT_CLK_LSB 16

// ==========================================================================
// Generator count, source codes and reset words
`define GCG_NUM_GEN      9
`define GCG_LAST_ID      4'h8
`define GCG_SRC_PAD      5'h01
`define GCG_SRC_LAST     5'h08
`define GCG_GEN0_RST     32'h00010600
`define GCG_GEN2_RST     32'h00010302

`endif

// File: verilog/gcg_divider.sv
// Divider of one generator: linear, power of two, or source pass-through.
`timescale 1ns/1ps

module gcg_divider #(
  parameter int DIV_W = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             run_i,
  input  wire logic             src_i,
  input  wire logic             divide_select_i,
  input  wire logic             duty_cycle_improve_i,
  input  wire logic [DIV_W-1:0] division_factor_i,
  output logic                  clk_o
);

  localparam int CW = DIV_W + 1;

  logic          src_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] limit_w;
  logic [CW-1:0] cnt_n_w;
  logic          rise_w;
  logic          tick_w;
  logic          bypass_w;

  // ========================================================================
  // Source edge detection and count limit
  assign rise_w   = src_i & ~src_q;
  assign bypass_w = !divide_select_i && (division_factor_i <= DIV_W'(1));
  // Power-of-two mode toggles every 2^factor rising edges.
  // Linear mode counts factor edges per period or half period.
  assign limit_w  = divide_select_i ?
                    ((division_factor_i > DIV_W'(DIV_W)) ?
                     (CW'(1) << DIV_W) : (CW'(1) << division_factor_i)) :
                    CW'(division_factor_i);
  // Counting both edges gives an even duty cycle for odd factors.
  assign tick_w   = (!divide_select_i && duty_cycle_improve_i) ?
                    (src_i ^ src_q) : rise_w;
  assign cnt_n_w  = (CW'(cnt_q + 1'b1) >= limit_w) ? '0 :
                    CW'(cnt_q + 1'b1);

  // Previous source level for edge detection.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src_i;
    end
  end

  // ========================================================================
  // Output clock generation
  // A stopped generator holds its output low.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || !run_i) begin
      cnt_q <= '0;
      clk_o <= 1'b0;
    end else if (bypass_w) begin
      cnt_q <= '0;
      clk_o <= src_i;
    end else if (tick_w) begin
      cnt_q <= cnt_n_w;
      if (divide_select_i || duty_cycle_improve_i) begin
        clk_o <= (cnt_n_w == '0) ? ~clk_o : clk_o;
      end else begin
        clk_o <= (cnt_n_w < (limit_w >> 1));
      end
    end
  end

  // ========================================================================
  // Checks
  property p_stop_low;
    @(posedge core_clk_i) disable iff (!resetn_i)
    !run_i |=> !clk_o;
  endproperty
  a_stop_low: assert property (p_stop_low)
    else $error("stopped generator output is not low");

  property p_bypass;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (run_i && bypass_w) |=> clk_o == $past(src_i);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("undivided output does not follow source");

  property p_pow_hold;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (run_i && divide_select_i && !rise_w) |=> $stable(clk_o);
  endproperty
  a_pow_hold: assert property (p_pow_hold)
    else $error("power-of-two output moved without source rise");

  property p_idc_hold;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (run_i && !bypass_w && !divide_select_i && duty_cycle_improve_i &&
     !tick_w) |=> $stable(clk_o);
  endproperty
  a_idc_hold: assert property (p_idc_hold)
    else $error("duty-corrected output moved without source edge");

  property p_count_bound;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (run_i && !bypass_w && tick_w) |=> cnt_q < $past(limit_w);
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("divider count reached its limit");

endmodule : gcg_divider

// File: verilog/gcg_pkg.sv
// Types shared by the generator control block.
package gcg_pkg;

  // Stored configuration of one generator, flags first as in bits 21:16.
  typedef struct packed {
    logic       keep_running_in_standby;
    logic       divide_select;
    logic       output_enable;
    logic       output_off_level;
    logic       duty_cycle_improve;
    logic       generator_enable;
    logic [4:0] source_select;
  } gcg_cfg_t;

endpackage : gcg_pkg

// File: verilog/gcg_sync.sv
// Two-stage synchroniser for levels arriving from outside the core clock.
`timescale 1ns/1ps

module gcg_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // ========================================================================
  // Synchroniser stages
  // The first stage is read only by the second stage.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : gcg_sync

// File: verilog/gcg_top.sv
// Control of nine clock generators behind one shared APB control register.
//
// How it works
// - In standby a pin-driving generator keeps running only with keep_running_in_standby set, else the pin shows the off level.
// - With output_enable clear, keep_running_in_standby is ignored and the generator runs only on a peripheral request.
// - With divide_select clear the output is the source divided by division_factor.
// - With divide_select set the output is the source divided by two to the power of division_factor plus one.
// - Divide_select clear with a factor of zero or one passes the source straight through.
// - With output_enable set the clock drives its pin unless that pin is the chosen source.
// - A stopped generator or a clear output_enable leaves the pin at output_off_level, unless the pin is the source.
// - Duty_cycle_improve gives an even duty cycle also for odd factors.
// - Generator_enable turns the generator on when one and off when zero.
// - Source_select codes 0 to 8 choose the nine clock sources, higher codes are reserved.
// - Reserved bits 31:22, 15:13 and 7:4 read as zero and software writes zeros.
// - The four-bit selector picks generator 0 to 8 for a write or a read, codes 9 to 15 are reserved.
// - Power reset restores every generator, generator 0 and 2 to their own words and the rest to their index.
// - User reset restores a generator other than 0 only when it feeds no locked clock and not the RTC.
// - User reset always restores generator 0, and qualifying others to their power-reset words.
`timescale 1ns/1ps
`include "gcg_defines.svh"

module gcg_top #(
  parameter int NUM_GEN = `GCG_NUM_GEN,
  parameter int DIV_W   = 16
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          user_reset_i,
  input  wire logic                          standby_i,
  input  wire logic [NUM_GEN-1:0]            periph_req_i,
  input  wire logic [NUM_GEN-1:0]            write_lock_i,
  input  wire logic [NUM_GEN-1:0]            rtc_source_i,
  input  wire logic [NUM_GEN-1:0][DIV_W-1:0] division_factor_i,
  input  wire logic [6:0]                    osc_clk_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [`GCG_ADDR_W-1:0]        paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  input  wire logic [3:0]                    pstrb_i,
  output logic      [31:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  input  wire logic [NUM_GEN-1:0]            pin_i,
  output logic      [NUM_GEN-1:0]            pin_o,
  output logic      [NUM_GEN-1:0]            pin_oe_o,
  output logic      [NUM_GEN-1:0]            gen_clk_o
);

  gcg_pkg::gcg_cfg_t [NUM_GEN-1:0] cfg_q;
  logic [3:0]                      sel_q;
  logic [NUM_GEN-1:0]              run_w;
  logic [NUM_GEN-1:0]              src_w;
  logic [6:0]                      osc_s;
  logic [NUM_GEN-1:0]              pin_s;
  logic                            setup_w;
  logic                            access_w;
  logic                            hit_ctrl_w;
  logic                            hit_stat_w;
  logic                            wr_ctrl_w;
  logic [3:0]                      wr_id_w;
  logic [31:0]                     rd_w;

  // ========================================================================
  // Helper functions
  // Unpacks the stored fields from a control word.
  function automatic gcg_pkg::gcg_cfg_t cfg_of(input logic [31:0] w);
    cfg_of = gcg_pkg::gcg_cfg_t'({w[`GCG_FLAG_LSB +: `GCG_FLAG_W],
                                  w[`GCG_SRC_LSB +: `GCG_SRC_W]});
  endfunction : cfg_of

  // Power-reset configuration of generator g; others keep only the index.
  function automatic gcg_pkg::gcg_cfg_t rst_cfg(input int g);
    if (g == 0) begin
      rst_cfg = cfg_of(`GCG_GEN0_RST);
    end else if (g == 2) begin
      rst_cfg = cfg_of(`GCG_GEN2_RST);
    end else begin
      rst_cfg = '0;
    end
  endfunction : rst_cfg

  // ========================================================================
  // Input synchronisers for oscillator and pad levels
  gcg_sync #(
    .W (NUM_GEN + 7)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    ({pin_i, osc_clk_i}),
    .sync_o     ({pin_s, osc_s})
  );

  // ========================================================================
  // APB decode; zero wait states, unmapped addresses answer with an error
  assign setup_w    = psel_i && !penable_i;
  assign access_w   = psel_i && penable_i;
  assign hit_ctrl_w = (paddr_i == `GCG_CTRL_OFF);
  assign hit_stat_w = (paddr_i == `GCG_STAT_OFF);
  assign wr_ctrl_w  = access_w && pwrite_i && hit_ctrl_w;
  assign pready_o   = 1'b1;
  assign pslverr_o  = access_w && !hit_ctrl_w && !hit_stat_w;
  // A byte write carries a new selector; otherwise the stored one is used.
  assign wr_id_w    = pstrb_i[0] ? pwdata_i[`GCG_ID_LSB +: `GCG_ID_W]
                                 : sel_q;

  // Read word of the selected generator, reserved bits held at zero.
  always_comb begin
    rd_w = '0;
    if (hit_ctrl_w) begin
      rd_w[`GCG_ID_LSB +: `GCG_ID_W] = sel_q;
      if (sel_q <= `GCG_LAST_ID) begin
        rd_w[`GCG_FLAG_LSB +: `GCG_FLAG_W] =
          cfg_q[sel_q][10:5];
        rd_w[`GCG_SRC_LSB +: `GCG_SRC_W] =
          cfg_q[sel_q].source_select;
      end
    end else if (hit_stat_w) begin
      rd_w[`GCG_STAT_RUN_LSB +: NUM_GEN] = run_w;
      rd_w[`GCG_STAT_CLK_LSB +: NUM_GEN] = gen_clk_o;
    end
  end

  // Read data is captured in the setup cycle and held for the access.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      prdata_o <= '0;
    end else if (setup_w && !pwrite_i) begin
      prdata_o <= rd_w;
    end
  end

  // ========================================================================
  // Generator selector
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || user_reset_i) begin
      sel_q <= '0;
    end else if (wr_ctrl_w && pstrb_i[0]) begin
      sel_q <= pwdata_i[`GCG_ID_LSB +: `GCG_ID_W];
    end
  end

  // ========================================================================
  // Per-generator configuration, source, divider and pin
  for (genvar g = 0; g < NUM_GEN; g++) begin : gen_g
    logic [8:0] srcs_w;

    // Power reset restores all; user reset skips locked or RTC feeders other than generator 0.
    always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
        cfg_q[g] <= rst_cfg(g);
      end else if (user_reset_i) begin
        if (g == 0 || !(write_lock_i[g] || rtc_source_i[g])) begin
          cfg_q[g] <= rst_cfg(g);
        end
      end else if (wr_ctrl_w && wr_id_w == 4'(g)) begin
        if (pstrb_i[1]) begin
          cfg_q[g].source_select <= pwdata_i[`GCG_SRC_LSB +: `GCG_SRC_W];
        end
        if (pstrb_i[2]) begin
          cfg_q[g][10:5] <= pwdata_i[`GCG_FLAG_LSB +: `GCG_FLAG_W];
        end
      end
    end

    // Source order follows the select codes; reserved codes give no clock.
    assign srcs_w   = {osc_s[6:1], gen_clk_o[1], pin_s[g], osc_s[0]};
    assign src_w[g] = (cfg_q[g].source_select <= `GCG_SRC_LAST) ?
                      srcs_w[cfg_q[g].source_select[3:0]] : 1'b0;

    // Pin-driving generators follow standby; others follow requests.
    assign run_w[g] = cfg_q[g].generator_enable &&
                      (cfg_q[g].output_enable ?
                       (!standby_i || cfg_q[g].keep_running_in_standby) :
                       periph_req_i[g]);

    gcg_divider #(
      .DIV_W (DIV_W)
    ) u_div (
      .core_clk_i           (core_clk_i),
      .resetn_i             (resetn_i),
      .run_i                (run_w[g]),
      .src_i                (src_w[g]),
      .divide_select_i      (cfg_q[g].divide_select),
      .duty_cycle_improve_i (cfg_q[g].duty_cycle_improve),
      .division_factor_i    (division_factor_i[g]),
      .clk_o                (gen_clk_o[g])
    );

    // The pin carries the clock or the off level, released when it is
    // the source.
    always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
        pin_o[g]    <= 1'b0;
        pin_oe_o[g] <= 1'b0;
      end else begin
        pin_oe_o[g] <= (cfg_q[g].source_select != `GCG_SRC_PAD);
        pin_o[g]    <= (cfg_q[g].output_enable && run_w[g]) ?
                       gen_clk_o[g] :
                       cfg_q[g].output_off_level;
      end
    end

    property p_off_level;
      @(posedge core_clk_i) disable iff (!resetn_i)
      !cfg_q[g].output_enable |=>
        pin_o[g] == $past(cfg_q[g].output_off_level);
    endproperty
    a_off_level: assert property (p_off_level)
      else $error("pin not at off level with output disabled");

    property p_pad_release;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (cfg_q[g].source_select == `GCG_SRC_PAD) |=> !pin_oe_o[g];
    endproperty
    a_pad_release: assert property (p_pad_release)
      else $error("pin driven while it is the source");

    property p_standby_stop;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (standby_i && cfg_q[g].output_enable &&
       !cfg_q[g].keep_running_in_standby) |=>
        pin_o[g] == $past(cfg_q[g].output_off_level) ##1 !gen_clk_o[g];
    endproperty
    a_standby_stop: assert property (p_standby_stop)
      else $error("generator ran in standby without permission");

    property p_no_request;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (!cfg_q[g].output_enable && !periph_req_i[g]) |=> !gen_clk_o[g];
    endproperty
    a_no_request: assert property (p_no_request)
      else $error("generator ran without a peripheral request");

    property p_power_reset;
      @(posedge core_clk_i) disable iff (!resetn_i)
      $rose(resetn_i) |-> cfg_q[g] == rst_cfg(g);
    endproperty
    a_power_reset: assert property (p_power_reset)
      else $error("wrong configuration after power reset");

    if (g != 0) begin : gen_keep
      property p_locked_keep;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (user_reset_i && (write_lock_i[g] || rtc_source_i[g])) |=>
          $stable(cfg_q[g]);
      endproperty
      a_locked_keep: assert property (p_locked_keep)
        else $error("user reset changed a protected generator");
    end
  end

  // ========================================================================
  // Register checks
  property p_user_gen0;
    @(posedge core_clk_i) disable iff (!resetn_i)
    user_reset_i |=> cfg_q[0] == rst_cfg(0);
  endproperty
  a_user_gen0: assert property (p_user_gen0)
    else $error("generator 0 not restored by user reset");

  property p_read_zero;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (access_w && !pwrite_i && hit_ctrl_w) |->
      (prdata_o & `GCG_RSV_MASK) == 32'h00000000;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("reserved bits read as nonzero");

  property p_read_sel;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (setup_w && !pwrite_i && hit_ctrl_w && sel_q <= `GCG_LAST_ID) |=>
      prdata_o[`GCG_ID_LSB +: `GCG_ID_W] == $past(sel_q) &&
      prdata_o[`GCG_SRC_LSB +: `GCG_SRC_W] ==
        $past(cfg_q[sel_q].source_select);
  endproperty
  a_read_sel: assert property (p_read_sel)
    else $error("read did not return the selected generator");

  property p_reserved_id;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (wr_ctrl_w && wr_id_w > `GCG_LAST_ID && !user_reset_i) |=>
      $stable(cfg_q);
  endproperty
  a_reserved_id: assert property (p_reserved_id)
    else $error("write to reserved selector changed a generator");

endmodule : gcg_top
